//--- tb_top.sv
// Self-checking bench for the transaction port
`timescale 1ns/10ps
module tb_top;
  logic        clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, err;
  logic [1:0]  lnk_width_i = 2'h2, lnk_mps_i = 2'h1;
  logic [63:0] lnk_rx_data_i = 64'h0, rx_packet_bus_o, tx_packet_bus_i, lnk_tx_data_o;
  logic        lnk_rx_sof_i = 1'b0, lnk_rx_eof_i = 1'b0, lnk_rx_rem_i = 1'b0;
  logic        lnk_rx_valid_i = 1'b0, rx_sof_o, rx_eof_o, rx_rem_o, rx_valid_o;
  logic        tx_sof_i, tx_eof_i, tx_rem_i, tx_valid_i;
  logic        lnk_tx_sof_o, lnk_tx_eof_o, lnk_tx_rem_o, lnk_tx_valid_o;
  logic [14:0] ack_lat_o, replay_tmo_o;
  logic        lane_rev_en_o, scramble_off_o, upcfg_cap_o, tx_l0s_block_o;
  logic [7:0]  link_num_o;
  logic [66:0] rxq[$], pk[$], ex[$];
  int          n_errors = 0, total_checks = 0, n;
  // ----------------------------------------
  // Row tables: APB {addr,wr,wdata,rdata,err}; timers {w,m,ack ovr,rpl ovr,ack,rpl}
  // ----------------------------------------
  localparam logic [77:0] AR [8] = '{
    {12'h000, 1'b0, 32'h0, 32'h0000_0021, 1'b0}, {12'h004, 1'b0, 32'h0, 32'h0, 1'b0},
    {12'h008, 1'b0, 32'h0, 32'h0, 1'b0}, {12'h010, 1'b0, 32'h0, 32'h09C0_0340, 1'b0},
    {12'h010, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b1}, {12'h014, 1'b1, 32'h1, 32'h0, 1'b1},
    {12'h014, 1'b0, 32'h0, 32'h0, 1'b1}, {12'h010, 1'b0, 32'h0, 32'h09C0_0340, 1'b0}};
  // Override results stay inside 15 bits
  localparam logic [97:0] TR [6] = '{
    {4'h9, 32'h0, 32'h0, 15'h0340, 15'h09C0}, {4'hF, 32'h0, 32'h0, 15'h04C0, 15'h0E40},
    {4'h9, 32'h0004_0123, 32'h0004_0456, 15'h0123, 15'h0456},
    {4'h9, 32'h0005_0010, 32'h0005_0020, 15'h0350, 15'h09E0},
    {4'h9, 32'h0007_0040, 32'h0007_0100, 15'h0300, 15'h08C0},
    {4'h9, 32'h0000_0123, 32'h0000_0456, 15'h0340, 15'h09C0}};
  // Message rows {code, root mode, always delivered}
  localparam logic [9:0] MR [12] = '{{8'h00, 2'b00}, {8'h19, 2'b00}, {8'h30, 2'b10},
    {8'h31, 2'b10}, {8'h33, 2'b10}, {8'h20, 2'b10}, {8'h23, 2'b10}, {8'h27, 2'b10},
    {8'h18, 2'b10}, {8'h1B, 2'b10}, {8'h30, 2'b01}, {8'h7E, 2'b01}};

  always #5 clk_i = ~clk_i;
  tlpo_port #(.TRIM_DIGEST(1'b1), .DBG_PORT_EN(1'b1)) uut (.*);
  tlpo_user_model um (.clk_i(clk_i), .tx_data_o(tx_packet_bus_i), .tx_sof_o(tx_sof_i),
    .tx_eof_o(tx_eof_i), .tx_rem_o(tx_rem_i), .tx_valid_o(tx_valid_i));
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1) rxq.push_back({rx_packet_bus_o, rx_sof_o, rx_eof_o, rx_rem_o});
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [66:0] e, input logic [66:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask
  task automatic rxp(input logic [66:0] p[$], input logic [66:0] e[$]);
    logic [66:0] g;
    rxq.delete();
    foreach (p[i]) begin
      {lnk_rx_data_i, lnk_rx_sof_i, lnk_rx_eof_i, lnk_rx_rem_i} <= p[i];
      lnk_rx_valid_i <= 1'b1;
      @(posedge clk_i);
    end
    lnk_rx_valid_i <= 1'b0;
    lnk_rx_data_i  <= ~lnk_rx_data_i;
    repeat (4) @(posedge clk_i);
    check("rx beat count", 67'(e.size()), 67'(rxq.size()));
    foreach (e[i]) begin
      g = (i < rxq.size()) ? rxq[i] : '0;
      // Low half of a short end beat carries nothing
      if (e[i][0]) g[34:3] = e[i][34:3];
      check("rx beat", e[i], g);
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      apb(AR[i][65], AR[i][77:66], AR[i][64:33]);
      if (!AR[i][65]) check("prdata", 67'(AR[i][32:1]), 67'(rd));
      check("pslverr", 67'(AR[i][0]), 67'(err));
    end
    $display("register table done");
    for (int i = 0; i < 6; i++) begin
      lnk_width_i <= TR[i][97:96];
      lnk_mps_i   <= TR[i][95:94];
      apb(1'b1, 12'h008, TR[i][93:62]);
      apb(1'b1, 12'h00C, TR[i][61:30]);
      repeat (3) @(posedge clk_i);
      check("ack timer", 67'(TR[i][29:15]), 67'(ack_lat_o));
      check("replay timer", 67'(TR[i][14:0]), 67'(replay_tmo_o));
    end
    $display("timer rows done");
    for (int i = 0; i < 12; i++) begin
      for (int f = 0; f < 2; f++) begin
        apb(1'b1, 12'h000, {29'h0, MR[i][1], f[0], 1'b1});
        pk = '{{8'h30, 48'h0, MR[i][9:2], 3'b100}, {64'h0123_4567_89AB_CDEF, 3'b010}};
        ex = pk;
        if (f == 0 && !MR[i][0]) ex.delete();
        rxp(pk, ex);
      end
    end
    $display("message rows done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    pk = '{{64'h0000_8001_1234_5678, 3'b100}, {64'hAAAA_BBBB_C0DE_C0DE, 3'b010},
      {64'h2000_8001_0000_0000, 3'b100}, {64'h1111_2222_3333_4444, 3'b000},
      {64'hD1D1_D1D1_0000_0000, 3'b011}};
    ex = '{{64'h0000_0001_1234_5678, 3'b100}, {64'hAAAA_BBBB_C0DE_C0DE, 3'b011},
      {64'h2000_0001_0000_0000, 3'b100}, {64'h1111_2222_3333_4444, 3'b010}};
    rxp(pk, ex);
    $display("digest trim done");
    for (int b = 0; b < 3; b++) begin
      for (int s = 0; s < 4; s += 3) begin
        apb(1'b1, 12'h000, 32'(1 + (b << 8) + (s << 10)));
        um.send({56'hFEDC_BA98_7654_32, 8'(b * 4 + s), 3'b110});
        n = 0;
        while (tx_valid_i !== 1'b1 && n < 20) begin
          @(posedge clk_i);
          n++;
        end
        n = 0;
        do begin
          @(posedge clk_i);
          n++;
        end while (lnk_tx_valid_o !== 1'b1 && n < 20);
        check("tx delay", 67'(2 + b + s), 67'(n));
        check("tx beat", {56'hFEDC_BA98_7654_32, 8'(b * 4 + s), 3'b110},
          {lnk_tx_data_o, lnk_tx_sof_o, lnk_tx_eof_o, lnk_tx_rem_o});
      end
    end
    $display("outbound pipeline done");
    apb(1'b1, 12'h004, 32'h0000_005A);
    apb(1'b1, 12'h000, 32'h0000_0059);
    check("options", 67'h0D_00, 67'({lane_rev_en_o, scramble_off_o, upcfg_cap_o,
      tx_l0s_block_o, link_num_o}));
    apb(1'b1, 12'h000, 32'h0000_0025);
    @(posedge clk_i);
    check("link number", 67'h5A_2, 67'({link_num_o, lane_rev_en_o, scramble_off_o, upcfg_cap_o,
      tx_l0s_block_o}));
    $display("link options done");
    nrst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("reset outputs", 67'h2, 67'({rx_valid_o, pready_o, lnk_tx_valid_o, ack_lat_o,
      link_num_o, upcfg_cap_o, lane_rev_en_o}));
    nrst_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, 12'h000, 32'h0);
    check("options after reset", 67'h21, 67'(rd));
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule // tb_top

//--- tlpo_delay.sv
// Selectable-depth register pipeline
`timescale 1ns/10ps
module tlpo_delay #(
  parameter int W   = 68,
  parameter int MAX = 3
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Stage count and data
  input  wire logic [1:0]   sel_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] stg_reg [MAX];
  logic [W-1:0] q_reg;

  // ----------------------------------------
  // Stage chain
  // ----------------------------------------
  for (genvar g = 0; g < MAX; g++) begin : g_stg
    if (g == 0) begin : g_first
      always_ff @(posedge clk_i) begin
        if (!nrst_i) stg_reg[g] <= '0;
        else         stg_reg[g] <= d_i;
      end
    end else begin : g_next
      always_ff @(posedge clk_i) begin
        if (!nrst_i) stg_reg[g] <= '0;
        else         stg_reg[g] <= stg_reg[g-1];
      end
    end
  end

  // ----------------------------------------
  // Tap select, clamped so a large count cannot index past the chain
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i)                   q_reg <= '0;
    else if (sel_i == 2'h0)        q_reg <= d_i;
    else if (int'(sel_i) > MAX)    q_reg <= stg_reg[MAX-1];
    else                           q_reg <= stg_reg[int'(sel_i)-1];
  end

  assign q_o = q_reg;
endmodule // tlpo_delay

//--- tlpo_params.svh
// Constants for the transaction port option block
`ifndef TLPO_PARAMS_SVH
`define TLPO_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TLPO_CTRL_OFS   12'h000
`define TLPO_LINK_OFS   12'h004
`define TLPO_ACKO_OFS   12'h008
`define TLPO_RPLO_OFS   12'h00C
`define TLPO_TMR_OFS    12'h010

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TLPO_C_TRIM     0
`define TLPO_C_FWD      1
`define TLPO_C_DSP      2
`define TLPO_C_LREV     3
`define TLPO_C_NOSCR    4
`define TLPO_C_UPCFG    5
`define TLPO_C_L0SDIS   6
`define TLPO_C_BRAM     8
`define TLPO_C_PIPE     10

// ----------------------------------------
// Override and timer fields
// ----------------------------------------
`define TLPO_O_VAL      0
`define TLPO_O_FN       16
`define TLPO_O_EN       18
`define TLPO_T_ACK      0
`define TLPO_T_RPL      16
`define TLPO_TMR_W      15

// ----------------------------------------
// Packet header fields and message codes
// ----------------------------------------
`define TLPO_TD_MASK    64'h0000_8000_0000_0000
`define TLPO_TD_BIT     47
`define TLPO_TYPE_HI    60
`define TLPO_TYPE_LO    59
`define TLPO_MSG_TYPE   2'h2
`define TLPO_M_UNLOCK   8'h00
`define TLPO_M_TURNOFF  8'h19
`define TLPO_M_PME      8'h18
`define TLPO_M_TOACK    8'h1B
`define TLPO_M_ECOR     8'h30
`define TLPO_M_ENF      8'h31
`define TLPO_M_EFAT     8'h33
`define TLPO_M_INTX     5'h04

`endif

//--- tlpo_pkg.sv
// Types shared by the transaction port option block
package tlpo_pkg;
  typedef logic [14:0] tlpo_tmr_t;
  typedef enum logic [1:0] {
    TLPO_OVR_ABS = 2'h0,
    TLPO_OVR_ADD = 2'h1,
    TLPO_OVR_SUB = 2'h3
  } tlpo_ovr_fn_t;
  typedef enum logic [1:0] {
    TLPO_BRAM_NONE = 2'h0,
    TLPO_BRAM_WR   = 2'h1,
    TLPO_BRAM_RW   = 2'h2
  } tlpo_bram_t;
endpackage

//--- tlpo_port.sv
// Transaction port: packet lanes, digest trim, message filter, link options
`timescale 1ns/10ps
`include "tlpo_params.svh"

// Functional notes
// - Trim inbound digest and clear TD bit
// - Endpoint forwards Unlock and PME_Turn_Off messages
// - Root port forwards error, INTx, PM messages
// - Buffer pipeline: write only or both paths
// - Built-in timers unless override is enabled
// - Ack override: absolute, add or subtract
// - Replay override: absolute, add or subtract
// - Timer table by link width and MPS
// - Lane reversal only when enabled
// - Scrambler off when forced, diagnostics only
// - Advertise not upconfigure capable when cleared
// - Transmitter never enters L0s when suppressed
// - Link number sent only when downstream facing
// - Selectable PIPE pipeline stage count
// - Attribute port changes settings at run time
// - Full 64-bit big-endian beats both ways
// - Byte 0 in bits 63:56, byte 8 next beat
// - Header is three or four words
// - TD set means trailing CRC32 word
// - Digest word excluded from length field
// - Inbound digest passed unchecked
module tlpo_port #(
  parameter bit         TRIM_DIGEST = 1'b0,
  parameter bit         MSG_FWD     = 1'b0,
  parameter bit         DOWNSTREAM  = 1'b0,
  parameter logic [1:0] BRAM_PIPE   = 2'h0,
  parameter bit         ACK_OVR_EN  = 1'b0,
  parameter logic [1:0] ACK_OVR_FN  = 2'h0,
  parameter logic [14:0] ACK_OVR_VAL = 15'h0000,
  parameter bit         RPL_OVR_EN  = 1'b0,
  parameter logic [1:0] RPL_OVR_FN  = 2'h0,
  parameter logic [14:0] RPL_OVR_VAL = 15'h0000,
  parameter logic [14:0] ACK_BASE   = 15'h0100,
  parameter logic [14:0] ACK_STEP   = 15'h0040,
  parameter logic [14:0] RPL_BASE   = 15'h0300,
  parameter logic [14:0] RPL_STEP   = 15'h00C0,
  parameter bit         LANE_REV    = 1'b0,
  parameter bit         NO_SCRAMBLE = 1'b0,
  parameter bit         UPCFG_CAP   = 1'b1,
  parameter bit         TX_L0S_DIS  = 1'b0,
  parameter logic [1:0] PIPE_STAGES = 2'h0,
  parameter logic [7:0] LINK_NUM    = 8'h00,
  parameter bit         DBG_PORT_EN = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // APB slave (attribute port)
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Link training state
  input  wire logic [1:0]  lnk_width_i,
  input  wire logic [1:0]  lnk_mps_i,
  // Inbound packets from the link
  input  wire logic [63:0] lnk_rx_data_i,
  input  wire logic        lnk_rx_sof_i,
  input  wire logic        lnk_rx_eof_i,
  input  wire logic        lnk_rx_rem_i,
  input  wire logic        lnk_rx_valid_i,
  // Inbound packets to the user
  output logic      [63:0] rx_packet_bus_o,
  output logic             rx_sof_o,
  output logic             rx_eof_o,
  output logic             rx_rem_o,
  output logic             rx_valid_o,
  // Outbound packets from the user
  input  wire logic [63:0] tx_packet_bus_i,
  input  wire logic        tx_sof_i,
  input  wire logic        tx_eof_i,
  input  wire logic        tx_rem_i,
  input  wire logic        tx_valid_i,
  // Outbound packets toward the PIPE side
  output logic      [63:0] lnk_tx_data_o,
  output logic             lnk_tx_sof_o,
  output logic             lnk_tx_eof_o,
  output logic             lnk_tx_rem_o,
  output logic             lnk_tx_valid_o,
  // Link and physical options
  output logic      [14:0] ack_lat_o,
  output logic      [14:0] replay_tmo_o,
  output logic             lane_rev_en_o,
  output logic             scramble_off_o,
  output logic             upcfg_cap_o,
  output logic             tx_l0s_block_o,
  output logic      [7:0]  link_num_o
);
  localparam logic [14:0] TMR_ZERO = 15'h0000;

  // ----------------------------------------
  // Option registers
  // ----------------------------------------
  logic        trim_reg, fwd_reg, dsp_reg;
  logic        lrev_reg, noscr_reg, upcfg_reg, l0s_reg;
  logic [1:0]  bram_reg, pipe_reg;
  logic [7:0]  lnum_reg;
  logic        acko_en_reg, rplo_en_reg;
  logic [1:0]  acko_fn_reg, rplo_fn_reg;
  logic [14:0] acko_val_reg, rplo_val_reg;
  logic [14:0] ack_reg, rpl_reg;
  logic [7:0]  link_out_reg;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic        pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic        hit, acc, wr_ok;

  always_comb begin
    hit = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr_i)
      `TLPO_CTRL_OFS: begin
        rd_next[`TLPO_C_TRIM]   = trim_reg;
        rd_next[`TLPO_C_FWD]    = fwd_reg;
        rd_next[`TLPO_C_DSP]    = dsp_reg;
        rd_next[`TLPO_C_LREV]   = lrev_reg;
        rd_next[`TLPO_C_NOSCR]  = noscr_reg;
        rd_next[`TLPO_C_UPCFG]  = upcfg_reg;
        rd_next[`TLPO_C_L0SDIS] = l0s_reg;
        rd_next[`TLPO_C_BRAM +: 2] = bram_reg;
        rd_next[`TLPO_C_PIPE +: 2] = pipe_reg;
      end
      `TLPO_LINK_OFS: rd_next[7:0] = lnum_reg;
      `TLPO_ACKO_OFS: begin
        rd_next[`TLPO_O_VAL +: 15] = acko_val_reg;
        rd_next[`TLPO_O_FN +: 2]   = acko_fn_reg;
        rd_next[`TLPO_O_EN]        = acko_en_reg;
      end
      `TLPO_RPLO_OFS: begin
        rd_next[`TLPO_O_VAL +: 15] = rplo_val_reg;
        rd_next[`TLPO_O_FN +: 2]   = rplo_fn_reg;
        rd_next[`TLPO_O_EN]        = rplo_en_reg;
      end
      `TLPO_TMR_OFS: begin
        rd_next[`TLPO_T_ACK +: 15] = ack_reg;
        rd_next[`TLPO_T_RPL +: 15] = rpl_reg;
      end
      default: hit = 1'b0;
    endcase
  end

  // One wait state: the answer always comes in the second access cycle
  assign acc = psel_i & penable_i & ~pready_reg;
  // Settings move only through the attribute port when it is built in
  assign wr_ok = psel_i & penable_i & pready_reg & pwrite_i & hit & DBG_PORT_EN;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & (~hit | (pwrite_i & ~DBG_PORT_EN) | (pwrite_i
                     & (paddr_i == `TLPO_TMR_OFS)));
      prdata_reg  <= (acc & ~pwrite_i) ? rd_next : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Option writes
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      trim_reg  <= TRIM_DIGEST;
      fwd_reg   <= MSG_FWD;
      dsp_reg   <= DOWNSTREAM;
      lrev_reg  <= LANE_REV;
      noscr_reg <= NO_SCRAMBLE;
      upcfg_reg <= UPCFG_CAP;
      l0s_reg   <= TX_L0S_DIS;
      bram_reg  <= BRAM_PIPE;
      pipe_reg  <= PIPE_STAGES;
    end else if (wr_ok && paddr_i == `TLPO_CTRL_OFS) begin
      trim_reg  <= pwdata_i[`TLPO_C_TRIM];
      fwd_reg   <= pwdata_i[`TLPO_C_FWD];
      dsp_reg   <= pwdata_i[`TLPO_C_DSP];
      lrev_reg  <= pwdata_i[`TLPO_C_LREV];
      noscr_reg <= pwdata_i[`TLPO_C_NOSCR];
      upcfg_reg <= pwdata_i[`TLPO_C_UPCFG];
      l0s_reg   <= pwdata_i[`TLPO_C_L0SDIS];
      bram_reg  <= pwdata_i[`TLPO_C_BRAM +: 2];
      pipe_reg  <= pwdata_i[`TLPO_C_PIPE +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) lnum_reg <= LINK_NUM;
    else if (wr_ok && paddr_i == `TLPO_LINK_OFS) lnum_reg <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acko_en_reg  <= ACK_OVR_EN;
      acko_fn_reg  <= ACK_OVR_FN;
      acko_val_reg <= ACK_OVR_VAL;
    end else if (wr_ok && paddr_i == `TLPO_ACKO_OFS) begin
      acko_en_reg  <= pwdata_i[`TLPO_O_EN];
      acko_fn_reg  <= pwdata_i[`TLPO_O_FN +: 2];
      acko_val_reg <= pwdata_i[`TLPO_O_VAL +: 15];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rplo_en_reg  <= RPL_OVR_EN;
      rplo_fn_reg  <= RPL_OVR_FN;
      rplo_val_reg <= RPL_OVR_VAL;
    end else if (wr_ok && paddr_i == `TLPO_RPLO_OFS) begin
      rplo_en_reg  <= pwdata_i[`TLPO_O_EN];
      rplo_fn_reg  <= pwdata_i[`TLPO_O_FN +: 2];
      rplo_val_reg <= pwdata_i[`TLPO_O_VAL +: 15];
    end
  end

  // ----------------------------------------
  // Timer table and overrides
  // ----------------------------------------
  tlpo_pkg::tlpo_tmr_t ack_tbl [16];
  tlpo_pkg::tlpo_tmr_t rpl_tbl [16];
  logic [3:0]          tbl_idx;

  for (genvar i = 0; i < 16; i++) begin : g_tbl
    assign ack_tbl[i] = ACK_BASE + 15'(ACK_STEP * i);
    assign rpl_tbl[i] = RPL_BASE + 15'(RPL_STEP * i);
  end
  assign tbl_idx = {lnk_width_i, lnk_mps_i};

  // Sums wrap silently; keeping them in range is the configuring side's job
  function automatic tlpo_pkg::tlpo_tmr_t ovr_apply(
    input tlpo_pkg::tlpo_tmr_t base,
    input tlpo_pkg::tlpo_tmr_t val,
    input logic                en,
    input logic [1:0]          fn
  );
    tlpo_pkg::tlpo_tmr_t res;
    res = base;
    if (en) begin
      case (tlpo_pkg::tlpo_ovr_fn_t'(fn))
        tlpo_pkg::TLPO_OVR_ABS: res = val;
        tlpo_pkg::TLPO_OVR_ADD: res = base + val;
        tlpo_pkg::TLPO_OVR_SUB: res = base - val;
        default:                res = base;
      endcase
    end
    return res;
  endfunction

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack_reg <= TMR_ZERO;
      rpl_reg <= TMR_ZERO;
    end else begin
      ack_reg <= ovr_apply(ack_tbl[tbl_idx], acko_val_reg, acko_en_reg,
                           acko_fn_reg);
      rpl_reg <= ovr_apply(rpl_tbl[tbl_idx], rplo_val_reg, rplo_en_reg,
                           rplo_fn_reg);
    end
  end

  // ----------------------------------------
  // Physical layer options
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) link_out_reg <= 8'h00;
    else         link_out_reg <= dsp_reg ? lnum_reg : 8'h00;
  end

  assign lane_rev_en_o  = lrev_reg;
  assign scramble_off_o = noscr_reg;
  assign upcfg_cap_o    = upcfg_reg;
  assign tx_l0s_block_o = l0s_reg;
  assign link_num_o     = link_out_reg;
  assign ack_lat_o      = ack_reg;
  assign replay_tmo_o   = rpl_reg;

  // ----------------------------------------
  // Inbound message filter
  // ----------------------------------------
  logic [7:0] mcode;
  logic       is_msg, ep_msg, rp_msg, msg_drop;

  assign mcode  = lnk_rx_data_i[7:0];
  assign is_msg = lnk_rx_data_i[`TLPO_TYPE_HI:`TLPO_TYPE_LO] == `TLPO_MSG_TYPE;
  assign ep_msg = (mcode == `TLPO_M_UNLOCK) | (mcode == `TLPO_M_TURNOFF);
  assign rp_msg = (mcode == `TLPO_M_ECOR) | (mcode == `TLPO_M_ENF)
                | (mcode == `TLPO_M_EFAT) | (mcode[7:3] == `TLPO_M_INTX)
                | (mcode == `TLPO_M_PME) | (mcode == `TLPO_M_TOACK);
  // Listed messages are consumed inside unless forwarding is on
  assign msg_drop = is_msg & ~fwd_reg & (dsp_reg ? rp_msg : ep_msg);

  // ----------------------------------------
  // Inbound digest trim
  // ----------------------------------------
  // One beat is held back: a digest alone in the last beat turns the
  // held beat into the new end of packet.
  logic        pkt_trim_reg, pkt_drop_reg;
  logic [63:0] hd_reg;
  logic        hs_reg, he_reg, hr_reg, hv_reg;
  logic        cur_trim, cur_drop, take, cut_last, emit;
  logic [63:0] rx_d_reg;
  logic        rx_s_reg, rx_e_reg, rx_r_reg, rx_v_reg;

  always_comb begin
    cur_trim = lnk_rx_sof_i ? (trim_reg & lnk_rx_data_i[`TLPO_TD_BIT]) : pkt_trim_reg;
    cur_drop = lnk_rx_sof_i ? msg_drop : pkt_drop_reg;
    take     = lnk_rx_valid_i & ~cur_drop;
    cut_last = take & cur_trim & lnk_rx_eof_i & lnk_rx_rem_i;
    emit     = hv_reg & (take | he_reg);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pkt_trim_reg <= 1'b0;
      pkt_drop_reg <= 1'b0;
    end else if (lnk_rx_valid_i && lnk_rx_sof_i) begin
      pkt_trim_reg <= trim_reg & lnk_rx_data_i[`TLPO_TD_BIT];
      pkt_drop_reg <= msg_drop;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hd_reg <= 64'h0000_0000_0000_0000;
      hs_reg <= 1'b0;
      he_reg <= 1'b0;
      hr_reg <= 1'b0;
      hv_reg <= 1'b0;
    end else if (take && !cut_last) begin
      hd_reg <= (lnk_rx_sof_i & cur_trim) ? (lnk_rx_data_i & ~`TLPO_TD_MASK)
                                          : lnk_rx_data_i;
      hs_reg <= lnk_rx_sof_i;
      he_reg <= lnk_rx_eof_i;
      hr_reg <= (lnk_rx_eof_i & cur_trim) ? 1'b1 : lnk_rx_rem_i;
      hv_reg <= 1'b1;
    end else if (emit || cut_last) begin
      hv_reg <= 1'b0;
    end
  end

  // Bytes keep their lanes: no swap, digest content is never checked
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_d_reg <= 64'h0000_0000_0000_0000;
      rx_s_reg <= 1'b0;
      rx_e_reg <= 1'b0;
      rx_r_reg <= 1'b0;
      rx_v_reg <= 1'b0;
    end else begin
      rx_d_reg <= hd_reg;
      rx_s_reg <= hs_reg & (emit | cut_last);
      rx_e_reg <= (he_reg | cut_last) & (emit | cut_last);
      rx_r_reg <= cut_last ? 1'b0 : hr_reg;
      rx_v_reg <= emit | cut_last;
    end
  end

  // ----------------------------------------
  // Outbound path: buffer pipeline, then PIPE pipeline
  // ----------------------------------------
  // Outbound packets pass unchecked and unaltered; the user owns
  // their format, header size and any digest.
  logic [67:0] tx_in, tx_mid, tx_out;
  logic [1:0]  bram_sel;

  assign tx_in = {tx_packet_bus_i, tx_sof_i, tx_eof_i, tx_rem_i,
                  tx_valid_i};
  // Write-only adds one stage, read and write add two
  assign bram_sel = (bram_reg == tlpo_pkg::TLPO_BRAM_WR) ? 2'h1
                  : (bram_reg == tlpo_pkg::TLPO_BRAM_NONE) ? 2'h0 : 2'h2;

  tlpo_delay #(
    .W   (68),
    .MAX (2)
  ) u_bram (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .sel_i  (bram_sel),
    .d_i    (tx_in),
    .q_o    (tx_mid)
  );

  tlpo_delay #(
    .W   (68),
    .MAX (3)
  ) u_pipe (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .sel_i  (pipe_reg),
    .d_i    (tx_mid),
    .q_o    (tx_out)
  );

  // ----------------------------------------
  // Output wiring
  // ----------------------------------------
  assign lnk_tx_data_o   = tx_out[67:4];
  assign lnk_tx_sof_o    = tx_out[3];
  assign lnk_tx_eof_o    = tx_out[2];
  assign lnk_tx_rem_o    = tx_out[1];
  assign lnk_tx_valid_o  = tx_out[0];
  assign rx_packet_bus_o = rx_d_reg;
  assign rx_sof_o        = rx_s_reg;
  assign rx_eof_o        = rx_e_reg;
  assign rx_rem_o        = rx_r_reg;
  assign rx_valid_o      = rx_v_reg;
  assign prdata_o        = prdata_reg;
  assign pready_o        = pready_reg;
  assign pslverr_o       = pslverr_reg;
endmodule // tlpo_port

//--- tlpo_port_properties.sv
// Concurrent checks on the transaction port pins
`timescale 1ns/10ps
module tlpo_port_chk #(
  parameter bit TRIM_DIGEST = 1'b0
) (
  // ----------------------------------------
  // Clock, reset and APB
  // ----------------------------------------
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // ----------------------------------------
  // Packet streams
  // ----------------------------------------
  input wire logic        lnk_rx_valid_i,
  input wire logic        lnk_rx_eof_i,
  input wire logic [63:0] rx_packet_bus_o,
  input wire logic        rx_sof_o,
  input wire logic        rx_eof_o,
  input wire logic        rx_valid_o,
  input wire logic        tx_valid_i,
  input wire logic        lnk_tx_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("attribute port answer late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  unmapped_err_a: assert property (pready_o && paddr_i > 12'h010 |->
      pslverr_o && prdata_o == 0)
    else $error("unmapped access not refused");
  timer_ro_a: assert property (pready_o && pwrite_i && paddr_i == 12'h010 |-> pslverr_o)
    else $error("timer write not refused");
  trim_flag_a: assert property (TRIM_DIGEST && rx_valid_o && rx_sof_o |->
      !rx_packet_bus_o[47])
    else $error("digest flag not cleared");
  rx_eof_lat_a: assert property (rx_valid_o && rx_eof_o |->
      $past(lnk_rx_valid_i && lnk_rx_eof_i) || $past(lnk_rx_valid_i && lnk_rx_eof_i, 2))
    else $error("inbound end beat without cause");
  tx_pass_a: assert property ($rose(tx_valid_i) |-> ##[2:7] lnk_tx_valid_o)
    else $error("outbound beat lost");
  reset_quiet_a: assert property (rx_valid_o || pready_o || lnk_tx_valid_o |->
      $past(nrst_i))
    else $error("output active right after reset");
endmodule // tlpo_port_chk

bind tlpo_port tlpo_port_chk #(.TRIM_DIGEST(TRIM_DIGEST)) chk (.*);

//--- tlpo_user_model.sv
// User application model that feeds outbound beats
`timescale 1ns/10ps
module tlpo_user_model (
  // Clock
  input  wire logic        clk_i,
  // Outbound beats
  output logic      [63:0] tx_data_o,
  output logic             tx_sof_o,
  output logic             tx_eof_o,
  output logic             tx_rem_o,
  output logic             tx_valid_o
);
  logic [66:0] q[$];
  initial begin
    {tx_data_o, tx_sof_o, tx_eof_o, tx_rem_o, tx_valid_o} = '0;
  end
  // Beats are queued as given; no format check, no digest is appended
  task automatic send(input logic [66:0] b);
    q.push_back(b);
  endtask
  always @(posedge clk_i) begin
    if (q.size() != 0) begin
      {tx_data_o, tx_sof_o, tx_eof_o, tx_rem_o} <= q.pop_front();
      tx_valid_o <= 1'b1;
    end else begin
      // Idle data lines toggle so stale data can never look valid
      tx_valid_o <= 1'b0;
      tx_data_o  <= ~tx_data_o;
    end
  end
endmodule // tlpo_user_model
